//--- include/csf_pkg.sv
// Shared constants and types for the counted sync message framer.
package csf_pkg;

  // ****************************************
  // Character codes
  // ****************************************
  localparam logic [7:0] SYN_CH = 8'h16;
  localparam logic [7:0] SOH_CH = 8'h01;
  localparam logic [7:0] ENQ_CH = 8'h05;
  localparam logic [7:0] DLE_CH = 8'h10;
  localparam logic [7:0] PAD_CH = 8'hff;
  // Control message subtypes carried in the count-low header slot.
  localparam logic [7:0] ACK_SUB = 8'h01;
  localparam logic [7:0] NAK_SUB = 8'h02;
  localparam logic [7:0] STATION_ADDR = 8'h01;

  // ****************************************
  // Header layout and sizes
  // ****************************************
  localparam int HDR_N = 6;
  localparam logic [2:0] HP_TYPE = 3'h0;
  localparam logic [2:0] HP_CNTL = 3'h1;
  localparam logic [2:0] HP_CNTH = 3'h2;
  localparam logic [2:0] HP_RESP = 3'h3;
  localparam logic [2:0] HP_SEQ = 3'h4;
  localparam logic [2:0] HP_ADDR = 3'h5;
  localparam logic [14:0] HDR_CRC_LO = 15'h0006;
  localparam logic [14:0] HDR_CRC_HI = 15'h0007;
  localparam logic [13:0] MAX_CNT = 14'h3fff;
  localparam logic [1:0] SYN_MIN = 2'h2;
  localparam logic [4:0] PAD_GAP_MIN = 5'h0e;
  localparam logic [15:0] CRC16_POLY_R = 16'ha001;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 20000000;
  localparam int RETX_TIMEOUT_MS = 1000;
  localparam int RETX_TIMEOUT_CYC = RETX_TIMEOUT_MS * (CLK_HZ / 1000);

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    K_DATA = 2'b00,
    K_CTRL = 2'b01,
    K_BOOT = 2'b10
  } csf_kind_e;

  typedef enum logic [1:0] {
    R_HUNT = 2'b00,
    R_SYNC = 2'b01,
    R_HDR = 2'b10,
    R_DATA = 2'b11
  } csf_rx_e;

  typedef enum logic [1:0] {
    T_GAP = 2'b00,
    T_SYN = 2'b01,
    T_HDR = 2'b10,
    T_DATA = 2'b11
  } csf_tx_e;

  typedef struct packed {
    csf_kind_e kind;
    logic [13:0] len;
    logic [7:0] seq;
  } csf_txreq_s;

  typedef struct packed {
    csf_kind_e kind;
    logic [13:0] len;
    logic [7:0] seq;
    logic [7:0] resp;
    logic [7:0] sub;
  } csf_rxhdr_s;

endpackage : csf_pkg

//--- rtl/csf_crc16.sv
// Byte-wide CRC-16 accumulator, reflected form, no final inversion.
`timescale 1ns/100ps
module csf_crc16 (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Byte feed
  input wire logic init_i,
  input wire logic en_i,
  input wire logic [7:0] data_i,
  // Result
  output logic [15:0] crc_o,
  output logic zero_o
);

  function automatic logic [15:0] csf_crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      fb = r[0] ^ d[i];
      r = r >> 1;
      if (fb)
        r = r ^ csf_pkg::CRC16_POLY_R;
    end
    return r;
  endfunction : csf_crc_step

  wire [15:0] seed = init_i ? 16'h0000 : crc_o;
  wire [15:0] crc_nxt = csf_crc_step(seed, data_i);
  // Feeding the check bytes low first leaves a zero remainder on a clean block.
  assign zero_o = (crc_nxt == 16'h0000);

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      crc_o <= 16'h0000;
    else if (en_i)
      crc_o <= crc_nxt;
  end

endmodule : csf_crc16

//--- rtl/csf_framer.sv
// Character framer and link bookkeeping for the counted sync message protocol.
//
// Functional notes
// - One leading type character selects message kind.
// - Header CRC-16 validated before count trusted.
// - Count gives data length, zero to 16383.
// - Take count bytes, then data CRC-16.
// - Content after type character is transparent.
// - Response field carries last good sequence.
// - Failed check queues a negative acknowledge.
// - Out-of-sequence message: no response, no update.
// - Retransmit on negative acknowledge with stale response, or on timeout.
// - Negative acknowledge queued without line turnaround.
// - Acknowledge rides next outgoing data header.
// - Separate acknowledge only without pending data.
// - One acknowledge covers up to 255.
// - Two sync characters before each type.
// - Idle time filled with sync characters; pad characters while pad_mode_i is set.
// - Pad gap at least fourteen character times.
// - Bootstrap starts with escape, transparent body.
// - CRC-16 polynomial x16+x15+x2+1.
`timescale 1ns/100ps
module csf_framer #(
  parameter int TIMEOUT_CYC = csf_pkg::RETX_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Receive character stream
  input wire logic [7:0] rx_char_i,
  input wire logic rx_valid_i,
  // Transmit character stream
  input wire logic tx_slot_i,
  output logic [7:0] tx_char_o,
  // Transmit user side
  input wire logic tx_req_i,
  input wire csf_pkg::csf_txreq_s tx_msg_i,
  input wire logic [7:0] tx_data_i,
  input wire logic pad_mode_i,
  output logic tx_accept_o,
  output logic tx_data_take_o,
  output logic tx_done_o,
  // Receive user side
  output logic [7:0] rx_byte_o,
  output logic rx_byte_valid_o,
  output csf_pkg::csf_rxhdr_s rx_hdr_o,
  output logic rx_ok_o,
  output logic rx_err_o,
  // Link status
  output logic rx_framed_o,
  output logic [7:0] far_ack_o,
  output logic retx_req_o
);

  // ****************************************
  // Character decode
  // ****************************************
  function automatic logic csf_is_type(input logic [7:0] ch);
    return (ch == csf_pkg::SOH_CH) || (ch == csf_pkg::ENQ_CH) || (ch == csf_pkg::DLE_CH);
  endfunction : csf_is_type

  function automatic csf_pkg::csf_kind_e csf_kind_of(input logic [7:0] ch);
    if (ch == csf_pkg::ENQ_CH)
      return csf_pkg::K_CTRL;
    if (ch == csf_pkg::DLE_CH)
      return csf_pkg::K_BOOT;
    return csf_pkg::K_DATA;
  endfunction : csf_kind_of

  function automatic logic [7:0] csf_type_char(input csf_pkg::csf_kind_e k);
    unique case (k)
      csf_pkg::K_DATA: return csf_pkg::SOH_CH;
      csf_pkg::K_CTRL: return csf_pkg::ENQ_CH;
      csf_pkg::K_BOOT: return csf_pkg::DLE_CH;
      default: return csf_pkg::SOH_CH;
    endcase
  endfunction : csf_type_char

  function automatic logic [7:0] csf_hdr_byte(input logic [2:0] p, input csf_pkg::csf_txreq_s m,
                                              input logic [7:0] sub, input logic [7:0] resp);
    logic ctl;
    ctl = (m.kind == csf_pkg::K_CTRL);
    unique case (p)
      csf_pkg::HP_TYPE: return csf_type_char(m.kind);
      csf_pkg::HP_CNTL: return ctl ? sub : m.len[7:0];
      csf_pkg::HP_CNTH: return ctl ? 8'h00 : {2'h0, m.len[13:8]};
      csf_pkg::HP_RESP: return resp;
      csf_pkg::HP_SEQ: return m.seq;
      default: return csf_pkg::STATION_ADDR;
    endcase
  endfunction : csf_hdr_byte

  // ****************************************
  // Receive framing
  // ****************************************
  csf_pkg::csf_rx_e rx_st_r;
  csf_pkg::csf_rx_e rx_st_nxt;
  logic [14:0] rx_idx_r;
  logic [1:0] rx_sync_r;
  logic [7:0] rx_hdr_r [0:csf_pkg::HDR_N-1];
  logic [7:0] rx_last_good_r;
  logic [7:0] far_ack_r;
  logic nak_pend_r;
  logic ack_pend_r;
  logic [15:0] rx_crc;
  logic rx_crc_zero;

  wire rx_is_syn = (rx_char_i == csf_pkg::SYN_CH);
  // Only the leading character is examined; everything after it is counted.
  wire rx_type_start = rx_valid_i && (rx_st_r == csf_pkg::R_SYNC) && csf_is_type(rx_char_i);
  wire [13:0] rx_len = {rx_hdr_r[csf_pkg::HP_CNTH][5:0], rx_hdr_r[csf_pkg::HP_CNTL]};
  wire csf_pkg::csf_kind_e rx_kind = csf_kind_of(rx_hdr_r[csf_pkg::HP_TYPE]);
  wire [7:0] rx_seq = rx_hdr_r[csf_pkg::HP_SEQ];
  wire [7:0] rx_resp = rx_hdr_r[csf_pkg::HP_RESP];
  wire [14:0] rx_len_x = {1'b0, rx_len};
  wire rx_hdr_end = rx_valid_i && (rx_st_r == csf_pkg::R_HDR) && (rx_idx_r == csf_pkg::HDR_CRC_HI);
  wire hdr_good = rx_hdr_end && rx_crc_zero;
  wire hdr_bad = rx_hdr_end && !rx_crc_zero;
  wire rx_has_data = (rx_kind != csf_pkg::K_CTRL) && (rx_len != 14'h0000);
  wire rx_in_data = rx_valid_i && (rx_st_r == csf_pkg::R_DATA);
  wire rx_dat_end = rx_in_data && (rx_idx_r == rx_len_x + 15'h0001);
  wire rx_end_ok = (hdr_good && !rx_has_data) || (rx_dat_end && rx_crc_zero);
  wire rx_end_bad = hdr_bad || (rx_dat_end && !rx_crc_zero);
  wire rx_in_seq = (rx_seq == rx_last_good_r + 8'h01);
  wire rx_data_ok = rx_end_ok && (rx_kind == csf_pkg::K_DATA);
  wire rx_seq_ok = rx_data_ok && rx_in_seq;
  wire rx_resp_seen = hdr_good && (rx_kind != csf_pkg::K_BOOT);
  wire rx_nak_seen = hdr_good && (rx_kind == csf_pkg::K_CTRL) &&
                     (rx_hdr_r[csf_pkg::HP_CNTL] == csf_pkg::NAK_SUB);
  wire rx_crc_en = rx_type_start || (rx_valid_i && (rx_st_r == csf_pkg::R_HDR)) || rx_in_data;
  wire rx_crc_init = rx_type_start || (rx_in_data && (rx_idx_r == 15'h0000));

  csf_crc16 u_rx_crc (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .init_i(rx_crc_init),
    .en_i(rx_crc_en),
    .data_i(rx_char_i),
    .crc_o(rx_crc),
    .zero_o(rx_crc_zero)
  );

  always_comb
  begin
    rx_st_nxt = rx_st_r;
    unique case (rx_st_r)
      csf_pkg::R_HUNT:
        if (rx_valid_i && rx_is_syn && (rx_sync_r == csf_pkg::SYN_MIN - 2'h1))
          rx_st_nxt = csf_pkg::R_SYNC;
      csf_pkg::R_SYNC:
        if (rx_valid_i && !rx_is_syn)
          rx_st_nxt = csf_is_type(rx_char_i) ? csf_pkg::R_HDR : csf_pkg::R_HUNT;
      csf_pkg::R_HDR:
        if (rx_hdr_end)
          rx_st_nxt = hdr_bad ? csf_pkg::R_HUNT : (rx_has_data ? csf_pkg::R_DATA : csf_pkg::R_SYNC);
      csf_pkg::R_DATA:
        if (rx_dat_end)
          rx_st_nxt = csf_pkg::R_SYNC;
    endcase
  end

  // A bad header count cannot be trusted, so framing is thrown away.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      rx_st_r <= csf_pkg::R_HUNT;
      rx_sync_r <= 2'h0;
      rx_idx_r <= 15'h0000;
    end
    else
    begin
      rx_st_r <= rx_st_nxt;
      if (rx_st_r != csf_pkg::R_HUNT)
        rx_sync_r <= 2'h0;
      else if (rx_valid_i)
        rx_sync_r <= rx_is_syn ? rx_sync_r + 2'h1 : 2'h0;
      if (rx_type_start || rx_hdr_end)
        rx_idx_r <= rx_type_start ? 15'h0001 : 15'h0000;
      else if (rx_valid_i && rx_st_r[1])
        rx_idx_r <= rx_idx_r + 15'h0001;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < csf_pkg::HDR_N; gi++)
    begin : g_hdr
      wire hit = (gi == 0) ? rx_type_start :
                 (rx_valid_i && (rx_st_r == csf_pkg::R_HDR) && (rx_idx_r == 15'(gi)));
      always_ff @(posedge ref_clk_i)
      begin
        if (!rst_n_i)
          rx_hdr_r[gi] <= 8'h00;
        else if (hit)
          rx_hdr_r[gi] <= rx_char_i;
      end
    end
  endgenerate

  // ****************************************
  // Acknowledge bookkeeping
  // ****************************************
  csf_pkg::csf_tx_e tx_st_r;
  logic [14:0] tx_idx_r;
  logic [4:0] gap_r;
  csf_pkg::csf_txreq_s cur_r;
  logic [7:0] cur_sub_r;
  logic [7:0] tx_hi_seq_r;
  logic [31:0] to_cnt_r;
  logic [15:0] tx_crc;

  wire gap_ok = !pad_mode_i || (gap_r >= csf_pkg::PAD_GAP_MIN);
  wire tx_want = nak_pend_r || tx_req_i || ack_pend_r;
  wire tx_start = tx_slot_i && (tx_st_r == csf_pkg::T_GAP) && gap_ok && tx_want;
  wire sel_nak = nak_pend_r;
  wire sel_user = !nak_pend_r && tx_req_i;
  wire sel_ack = !nak_pend_r && !tx_req_i;
  wire user_data = sel_user && (tx_msg_i.kind == csf_pkg::K_DATA);
  wire nak_clr = tx_start && sel_nak;
  wire ack_clr = tx_start && (sel_ack || user_data);
  wire outstanding = (far_ack_r != tx_hi_seq_r);
  wire to_expire = outstanding && (to_cnt_r == 32'(TIMEOUT_CYC - 1));
  wire retx_now = (rx_nak_seen && (rx_resp != tx_hi_seq_r)) || to_expire;

  // Set wins over clear so an error in the send cycle is not lost.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      rx_last_good_r <= 8'h00;
      far_ack_r <= 8'h00;
      nak_pend_r <= 1'b0;
      ack_pend_r <= 1'b0;
      to_cnt_r <= 32'h0000_0000;
      retx_req_o <= 1'b0;
    end
    else
    begin
      if (rx_seq_ok)
        rx_last_good_r <= rx_seq;
      if (rx_resp_seen)
        far_ack_r <= rx_resp;
      nak_pend_r <= rx_end_bad || (nak_pend_r && !nak_clr);
      ack_pend_r <= rx_seq_ok || (ack_pend_r && !ack_clr);
      if (!outstanding || rx_resp_seen || to_expire || (tx_start && user_data))
        to_cnt_r <= 32'h0000_0000;
      else
        to_cnt_r <= to_cnt_r + 32'h0000_0001;
      retx_req_o <= retx_now;
    end
  end

  // ****************************************
  // Transmit sequencing
  // ****************************************
  wire [14:0] cur_len_x = {1'b0, cur_r.len};
  wire tx_has_data = (cur_r.kind != csf_pkg::K_CTRL) && (cur_r.len != 14'h0000);
  wire hdr_last = (tx_idx_r == csf_pkg::HDR_CRC_HI);
  wire dat_last = (tx_idx_r == cur_len_x + 15'h0001);
  wire in_hdr_body = (tx_st_r == csf_pkg::T_HDR) && (tx_idx_r < csf_pkg::HDR_CRC_LO);
  wire in_dat_body = (tx_st_r == csf_pkg::T_DATA) && (tx_idx_r < cur_len_x);
  wire at_crc_lo = (tx_st_r == csf_pkg::T_HDR) ? (tx_idx_r == csf_pkg::HDR_CRC_LO)
                                                : (tx_idx_r == cur_len_x);
  wire tx_end = tx_slot_i && (((tx_st_r == csf_pkg::T_HDR) && hdr_last && !tx_has_data) ||
                              ((tx_st_r == csf_pkg::T_DATA) && dat_last));
  wire [7:0] hdr_ch = csf_hdr_byte(tx_idx_r[2:0], cur_r, cur_sub_r, rx_last_good_r);
  wire [7:0] crc_ch = at_crc_lo ? tx_crc[7:0] : tx_crc[15:8];
  wire [7:0] gap_ch = (pad_mode_i && !tx_start) ? csf_pkg::PAD_CH : csf_pkg::SYN_CH;
  logic [7:0] tx_char_nxt;
  csf_pkg::csf_tx_e tx_st_nxt;

  always_comb
  begin
    unique case (tx_st_r)
      csf_pkg::T_GAP: tx_char_nxt = gap_ch;
      csf_pkg::T_SYN: tx_char_nxt = csf_pkg::SYN_CH;
      csf_pkg::T_HDR: tx_char_nxt = in_hdr_body ? hdr_ch : crc_ch;
      csf_pkg::T_DATA: tx_char_nxt = in_dat_body ? tx_data_i : crc_ch;
    endcase
  end

  csf_crc16 u_tx_crc (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .init_i(tx_idx_r == 15'h0000),
    .en_i(tx_slot_i && (in_hdr_body || in_dat_body)),
    .data_i(tx_char_nxt),
    .crc_o(tx_crc),
    .zero_o()
  );

  always_comb
  begin
    tx_st_nxt = tx_st_r;
    unique case (tx_st_r)
      csf_pkg::T_GAP:
        if (tx_start)
          tx_st_nxt = csf_pkg::T_SYN;
      csf_pkg::T_SYN:
        if (tx_slot_i && (tx_idx_r == 15'(csf_pkg::SYN_MIN - 2'h1)))
          tx_st_nxt = csf_pkg::T_HDR;
      csf_pkg::T_HDR:
        if (tx_slot_i && hdr_last)
          tx_st_nxt = tx_has_data ? csf_pkg::T_DATA : csf_pkg::T_GAP;
      csf_pkg::T_DATA:
        if (tx_slot_i && dat_last)
          tx_st_nxt = csf_pkg::T_GAP;
    endcase
  end

  // Even back-to-back traffic gets two sync characters ahead of every type character.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      tx_st_r <= csf_pkg::T_GAP;
      tx_idx_r <= 15'h0000;
      gap_r <= 5'h00;
      cur_r <= '0;
      cur_sub_r <= 8'h00;
      tx_hi_seq_r <= 8'h00;
      tx_char_o <= csf_pkg::SYN_CH;
    end
    else if (tx_slot_i)
    begin
      tx_st_r <= tx_st_nxt;
      tx_char_o <= tx_char_nxt;
      tx_idx_r <= (tx_st_nxt != tx_st_r) ? 15'h0000 : tx_idx_r + 15'h0001;
      if (tx_start)
        tx_idx_r <= 15'h0001;
      if (tx_end)
        gap_r <= 5'h00;
      else if ((tx_st_r == csf_pkg::T_GAP) && (gap_r != 5'h1f))
        gap_r <= gap_r + 5'h01;
      if (tx_start)
      begin
        cur_r <= sel_user ? tx_msg_i :
                 csf_pkg::csf_txreq_s'{kind: csf_pkg::K_CTRL, len: 14'h0000, seq: 8'h00};
        cur_sub_r <= sel_nak ? csf_pkg::NAK_SUB : csf_pkg::ACK_SUB;
      end
      if (tx_start && user_data)
        tx_hi_seq_r <= tx_msg_i.seq;
    end
  end

  // ****************************************
  // User-facing registered outputs
  // ****************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      tx_accept_o <= 1'b0;
      tx_data_take_o <= 1'b0;
      tx_done_o <= 1'b0;
      rx_byte_o <= 8'h00;
      rx_byte_valid_o <= 1'b0;
      rx_hdr_o <= '0;
      rx_ok_o <= 1'b0;
      rx_err_o <= 1'b0;
      rx_framed_o <= 1'b0;
    end
    else
    begin
      tx_accept_o <= tx_start && sel_user;
      tx_data_take_o <= tx_slot_i && in_dat_body;
      tx_done_o <= tx_end;
      rx_byte_o <= rx_char_i;
      rx_byte_valid_o <= rx_in_data && (rx_idx_r < rx_len_x);
      if (hdr_good)
        rx_hdr_o <= '{kind: rx_kind, len: rx_len, seq: rx_seq, resp: rx_resp,
                      sub: rx_hdr_r[csf_pkg::HP_CNTL]};
      rx_ok_o <= rx_end_ok && !(rx_data_ok && !rx_in_seq);
      rx_err_o <= rx_end_bad;
      rx_framed_o <= (rx_st_nxt != csf_pkg::R_HUNT);
    end
  end

  assign far_ack_o = far_ack_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  lead_type_a : assert property (
    (tx_st_r == csf_pkg::T_HDR && tx_idx_r == 15'h0000 && tx_slot_i) |=> csf_is_type(tx_char_o))
    else $error("leading character is not a type code");
  hdr_crc_gate_a : assert property (
    hdr_bad |=> (rx_st_r == csf_pkg::R_HUNT) && !rx_ok_o && rx_err_o)
    else $error("bad header check did not drop framing");
  data_count_a : assert property (
    rx_dat_end |=> (rx_st_r == csf_pkg::R_SYNC) && (rx_ok_o || rx_err_o || !rx_in_seq))
    else $error("data field did not close after count and check");
  resp_field_a : assert property (
    (tx_slot_i && tx_st_r == csf_pkg::T_HDR && tx_idx_r == 15'(csf_pkg::HP_RESP))
    |=> tx_char_o == $past(rx_last_good_r))
    else $error("response field is not the last good sequence");
  nak_queue_a : assert property (
    rx_end_bad |=> nak_pend_r)
    else $error("check failure did not queue a negative acknowledge");
  seq_hold_a : assert property (
    (rx_data_ok && !rx_in_seq) |=> $stable(rx_last_good_r) && !rx_ok_o && !$rose(ack_pend_r))
    else $error("out of sequence message changed state");
  retx_nak_a : assert property (
    (rx_nak_seen && rx_resp != tx_hi_seq_r) |=> retx_req_o)
    else $error("stale response did not request a resend");
  ack_only_idle_a : assert property (
    (tx_start && !nak_pend_r && !tx_req_i)
    |=> (cur_r.kind == csf_pkg::K_CTRL) && (cur_sub_r == csf_pkg::ACK_SUB) && $past(ack_pend_r))
    else $error("separate acknowledge without cause");
  two_sync_a : assert property (
    (tx_start) |=> tx_char_o == csf_pkg::SYN_CH ##0 (tx_st_r == csf_pkg::T_SYN))
    else $error("message did not open with sync");
  pad_gap_a : assert property (
    (tx_slot_i && tx_st_r == csf_pkg::T_GAP && pad_mode_i && gap_r < csf_pkg::PAD_GAP_MIN)
    |=> tx_char_o == csf_pkg::PAD_CH && tx_st_r == csf_pkg::T_GAP)
    else $error("pad gap shorter than required");

  good_msg_c : cover property (rx_seq_ok);
  nak_send_c : cover property (nak_clr);
  retx_c : cover property (retx_req_o);
  data_tx_c : cover property (tx_end && tx_has_data);

endmodule : csf_framer

//--- verification/csf_remote.sv
// Remote station model: sends framed messages and records every transmitted character.
`timescale 1ns/100ps
module csf_remote (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Line towards the framer
  input wire logic [7:0] tx_char_i,
  output logic tx_slot_o,
  output logic [7:0] rx_char_o,
  output logic rx_valid_o
);
  logic [7:0] txq[$];
  logic [1:0] slot_cnt_r = 2'h0;

  initial
  begin
    rx_char_o = 8'h00;
    rx_valid_o = 1'b0;
  end

  // ****************************************
  // Transmit line: one slot every four clocks
  // ****************************************
  // The character loaded by the previous slot is still standing at this slot.
  always @(posedge ref_clk_i)
  begin
    slot_cnt_r <= rst_n_i ? slot_cnt_r + 2'h1 : 2'h0;
    if (tx_slot_o)
      txq.push_back(tx_char_i);
  end
  assign tx_slot_o = rst_n_i && (slot_cnt_r == 2'h3);

  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++)
      c = c[0] ? ((c >> 1) ^ csf_pkg::CRC16_POLY_R) : (c >> 1);
    return c;
  endfunction : crc16

  // ****************************************
  // Receive line: one character every two clocks
  // ****************************************
  // Between characters the line shows the complement of the last character, never the last value.
  task automatic put(input logic [7:0] ch);
    @(posedge ref_clk_i);
    rx_char_o <= ch;
    rx_valid_o <= 1'b1;
    @(posedge ref_clk_i);
    rx_valid_o <= 1'b0;
    rx_char_o <= ~ch;
  endtask : put

  task automatic send(input logic [7:0] t, input logic [7:0] b1, input logic [7:0] resp,
                      input logic [7:0] seq, input logic [7:0] d[$], input logic [1:0] bad);
    logic [7:0] h[6];
    logic [15:0] c;
    h = '{t, b1, 8'h00, resp, seq, csf_pkg::STATION_ADDR};
    c = 16'h0000;
    put(csf_pkg::SYN_CH);
    put(csf_pkg::SYN_CH);
    foreach (h[k])
    begin
      put(h[k]);
      c = crc16(c, h[k]);
    end
    c[0] = c[0] ^ bad[1];
    put(c[7:0]);
    put(c[15:8]);
    if (t != csf_pkg::ENQ_CH)
    begin
      c = 16'h0000;
      foreach (d[k])
      begin
        put(d[k]);
        c = crc16(c, d[k]);
      end
      c[0] = c[0] ^ bad[0];
      put(c[7:0]);
      put(c[15:8]);
    end
  endtask : send
endmodule : csf_remote

//--- verification/tb_top.sv
// Self-checking testbench for the counted sync message framer.
`timescale 1ns/100ps
module tb_top;
  logic ref_clk_i, rst_n_i, rx_valid_i, tx_slot_i, tx_req_i, pad_mode_i;
  logic [7:0] rx_char_i, tx_char_o, tx_data_i, rx_byte_o, far_ack_o;
  logic tx_accept_o, tx_data_take_o, tx_done_o, rx_byte_valid_o, rx_ok_o, rx_err_o;
  logic rx_framed_o, retx_req_o;
  csf_pkg::csf_txreq_s tx_msg_i;
  csf_pkg::csf_rxhdr_s rx_hdr_o;
  logic [7:0] rxq[$], d[$], e[$], txd[4];
  logic [15:0] rnd = 16'h23ca;
  int bad_count = 0, check_count = 0, ok_n = 0, err_n = 0, retx_n = 0, didx = 0, cyc = 0, fi = 0;

  csf_framer #(.TIMEOUT_CYC(4000)) csf_framer_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .rx_char_i(rx_char_i), .rx_valid_i(rx_valid_i), .tx_slot_i(tx_slot_i),
    .tx_char_o(tx_char_o), .tx_req_i(tx_req_i), .tx_msg_i(tx_msg_i), .tx_data_i(tx_data_i),
    .pad_mode_i(pad_mode_i), .tx_accept_o(tx_accept_o), .tx_data_take_o(tx_data_take_o),
    .tx_done_o(tx_done_o), .rx_byte_o(rx_byte_o), .rx_byte_valid_o(rx_byte_valid_o),
    .rx_hdr_o(rx_hdr_o), .rx_ok_o(rx_ok_o), .rx_err_o(rx_err_o), .rx_framed_o(rx_framed_o),
    .far_ack_o(far_ack_o), .retx_req_o(retx_req_o));
  csf_remote csf_remote_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .tx_char_i(tx_char_o),
    .tx_slot_o(tx_slot_i), .rx_char_o(rx_char_i), .rx_valid_o(rx_valid_i));

  assign tx_data_i = txd[didx];
  always #25 ref_clk_i = ~ref_clk_i;

  // ****************************************
  // Monitor, timeout and helpers
  // ****************************************
  always @(posedge ref_clk_i)
  begin
    if (rx_byte_valid_o === 1'b1)
      rxq.push_back(rx_byte_o);
    ok_n += int'(rx_ok_o === 1'b1);
    err_n += int'(rx_err_o === 1'b1);
    retx_n += int'(retx_req_o === 1'b1);
    if (tx_data_take_o === 1'b1)
      didx <= didx + 1;
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      test_done();
    end
  end

  function automatic logic [7:0] rb();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return rnd[7:0];
  endfunction : rb

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic chk_frame(input logic [7:0] t, input logic [7:0] b1, input logic [7:0] resp,
                           input logic [7:0] seq, input logic [7:0] dq[$]);
    logic [15:0] c;
    logic [7:0] f[$];
    fi = -1;
    for (int k = csf_remote_inst.txq.size() - 1; k >= 2; k--)
      if (csf_remote_inst.txq[k] === t && csf_remote_inst.txq[k-1] === csf_pkg::SYN_CH &&
          csf_remote_inst.txq[k-2] === csf_pkg::SYN_CH)
        fi = k;
    chk(fi >= 0, 1'b1);
    if (fi < 0)
      return;
    f = csf_remote_inst.txq[fi:$];
    chk({f[2], f[1]}, {8'h00, b1});
    chk(f[3], resp);
    if (t == csf_pkg::SOH_CH)
      chk(f[4], seq);
    c = 16'h0000;
    for (int k = 0; k < 6; k++)
      c = csf_remote_inst.crc16(c, f[k]);
    chk({f[7], f[6]}, c);
    c = 16'h0000;
    foreach (dq[k])
    begin
      chk(f[8+k], dq[k]);
      c = csf_remote_inst.crc16(c, dq[k]);
    end
    if (dq.size() > 0)
      chk({f[9+dq.size()], f[8+dq.size()]}, c);
  endtask : chk_frame

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    ref_clk_i = 1'b0;
    rst_n_i = 1'b0;
    tx_req_i = 1'b0;
    pad_mode_i = 1'b0;
    tx_msg_i = '0;
    txd = '{8'h00, 8'h00, 8'h00, 8'h00};
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(negedge ref_clk_i);
    chk(tx_char_o, csf_pkg::SYN_CH);
    $display("test 1 done");
    // Payload holds sync and type codes on purpose: they must pass as plain data.
    d = '{csf_pkg::SYN_CH, csf_pkg::SOH_CH, rb()};
    csf_remote_inst.txq.delete();
    csf_remote_inst.send(csf_pkg::SOH_CH, 8'h03, 8'h00, 8'h01, d, 1'b0);
    repeat (4) @(negedge ref_clk_i);
    chk(rxq.size(), 3);
    foreach (d[k])
      chk(rxq[k], d[k]);
    chk(ok_n, 1);
    chk({rx_hdr_o.kind, rx_hdr_o.len, rx_hdr_o.seq}, {csf_pkg::K_DATA, 14'h0003, 8'h01});
    repeat (200) @(posedge ref_clk_i);
    chk_frame(csf_pkg::ENQ_CH, csf_pkg::ACK_SUB, 8'h01, 8'h00, e);
    $display("test 2 done");
    d = '{rb(), rb()};
    csf_remote_inst.txq.delete();
    csf_remote_inst.send(csf_pkg::SOH_CH, 8'h02, 8'h00, 8'h02, d, 1'b1);
    repeat (4) @(negedge ref_clk_i);
    chk(err_n, 1);
    repeat (200) @(posedge ref_clk_i);
    chk_frame(csf_pkg::ENQ_CH, csf_pkg::NAK_SUB, 8'h01, 8'h00, e);
    $display("test 3 done");
    csf_remote_inst.txq.delete();
    csf_remote_inst.send(csf_pkg::SOH_CH, 8'h02, 8'h00, 8'h03, d, 1'b0);
    repeat (200) @(posedge ref_clk_i);
    chk(ok_n, 1);
    e = csf_remote_inst.txq.find(x) with (x == csf_pkg::ENQ_CH);
    chk(csf_remote_inst.txq.size() > 0 && e.size() == 0, 1'b1);
    $display("test 4 done");
    rxq.delete();
    csf_remote_inst.send(csf_pkg::DLE_CH, 8'h02, 8'h00, 8'h00, d, 1'b0);
    repeat (4) @(negedge ref_clk_i);
    chk({rx_hdr_o.kind, rxq[0], rxq[1], 8'(ok_n)}, {csf_pkg::K_BOOT, d[0], d[1], 8'h02});
    $display("test 5 done");
    txd = '{rb(), rb(), 8'h00, 8'h00};
    csf_remote_inst.txq.delete();
    @(posedge ref_clk_i);
    tx_msg_i <= '{kind: csf_pkg::K_DATA, len: 14'h0002, seq: 8'h01};
    tx_req_i <= 1'b1;
    pad_mode_i <= 1'b1;
    for (int k = 0; k < 100 && tx_accept_o !== 1'b1; k++) @(negedge ref_clk_i);
    chk(tx_accept_o, 1'b1);
    @(posedge ref_clk_i);
    tx_req_i <= 1'b0;
    for (int k = 0; k < 200 && tx_done_o !== 1'b1; k++) @(negedge ref_clk_i);
    chk(tx_done_o, 1'b1);
    repeat (8) @(posedge ref_clk_i);
    d = '{txd[0], txd[1]};
    chk_frame(csf_pkg::SOH_CH, 8'h02, 8'h01, 8'h01, d);
    $display("test 6 done");
    // A header that fails its check drops framing; the reply must sit out the pad gap.
    csf_remote_inst.send(csf_pkg::SOH_CH, 8'h02, 8'h00, 8'h02, d, 2'h2);
    repeat (200) @(posedge ref_clk_i);
    chk({8'(err_n), 7'h00, rx_framed_o}, 16'h0200);
    chk_frame(csf_pkg::ENQ_CH, csf_pkg::NAK_SUB, 8'h01, 8'h00, e);
    for (int k = 3; k < 17; k++)
      chk(csf_remote_inst.txq[fi - k], csf_pkg::PAD_CH);
    $display("test 6b done");
    retx_n = 0;
    csf_remote_inst.send(csf_pkg::ENQ_CH, csf_pkg::NAK_SUB, 8'h00, 8'h00, e, 1'b0);
    repeat (6) @(negedge ref_clk_i);
    chk({far_ack_o, 8'(retx_n)}, {8'h00, 8'h01});
    csf_remote_inst.send(csf_pkg::ENQ_CH, csf_pkg::ACK_SUB, 8'h01, 8'h00, e, 1'b0);
    repeat (6) @(negedge ref_clk_i);
    chk(far_ack_o, 8'h01);
    $display("test 7 done");
    test_done();
  end
endmodule : tb_top
